/* rtl/acc_write_shift.sv */
/*
  Two independent 40-bit accumulators with microcode write control, preload
  from the Y port on rising and falling edges, and a steered output shifter.
  Assumes the sequencer holds the instruction word stable for a whole clock
  period, sets Y once for the falling edge and again for the rising edge,
  and that software reaches the shift amounts over APB.
*/
`timescale 1ns/1ps
module acc_write_shift
  import acc_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [15:0]         ucode_word,
  input  wire logic [ACC_W-1:0]    adder_result,
  input  wire logic                adder_twos,
  input  wire logic [WORD_W-1:0]   y_port,
  input  wire logic [1:0]          out_src,
  input  wire logic [1:0]          out_mode,
  input  wire logic                status_write,
  input  wire logic                shift_write,
  input  wire logic                shift_write_sel,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output      logic [31:0]         prdata_r,
  output      logic                pready_r,
  output      logic                pslverr_r,
  output      logic [ACC_W-1:0]    shifted_out_r,
  output      logic [1:0]          acc_twos_r
);

  // ****************************************************************
  // Accumulators
  // ****************************************************************
  logic [3:0]        write_code [2];
  acc_val_type       acc_val    [2];
  logic [ACC_W-1:0]  acc_flat   [2];

  assign write_code[0] = ucode_word[FIRST_CODE_MSB:FIRST_CODE_LSB];
  assign write_code[1] = ucode_word[SECOND_CODE_MSB:SECOND_CODE_LSB];

  // Each field is the xor of a rising-edge and a falling-edge flop, so that a
  // field can be loaded on either edge while every flop keeps a single driver.
  for (genvar a = 0; a < 2; a++) begin : g_acc
    acc_ctl_type  ctl;
    acc_val_type  rise_r;
    acc_val_type  fall_r;
    acc_val_type  load_val;
    logic         sign_r;

    assign ctl = decode_write(write_code[a]);
    assign acc_val[a] = rise_r ^ fall_r;
    assign acc_flat[a] = {acc_val[a].guard_extension_field, acc_val[a].upr, acc_val[a].lwr};

    // Candidate values from the adder result or the Y preload path.
    assign load_val.lwr = (ctl.lwr_src == SRC_ADDER) ? adder_result[15:0] :
                          (ctl.lwr_src == SRC_Y)     ? y_port : WORD_RESET;
    assign load_val.upr = (ctl.upr_src == SRC_ADDER) ? adder_result[31:16] :
                          (ctl.upr_src == SRC_Y)     ? y_port :
                          (ctl.upr_src == SRC_SEXT)  ? {WORD_W{y_port[WORD_W-1]}} :
                          WORD_RESET;
    assign load_val.guard_extension_field = (ctl.ext_src == SRC_ADDER) ? adder_result[39:32] :
                          (ctl.ext_src == SRC_Y)     ? y_port[EXT_W-1:0] :
                          (ctl.ext_src == SRC_SEXT)  ? {EXT_W{load_val.upr[WORD_W-1]}} :
                          EXT_RESET;

    // Rising-edge loads; keep means the flop holds its own value.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rise_r <= '{EXT_RESET, WORD_RESET, WORD_RESET};
      end else begin
        if (ctl.ext_src != SRC_KEEP && !ctl.ext_fall) begin
          rise_r.guard_extension_field <= load_val.guard_extension_field ^ fall_r.guard_extension_field;
        end
        if (ctl.upr_src != SRC_KEEP && !ctl.upr_fall) begin
          rise_r.upr <= load_val.upr ^ fall_r.upr;
        end
        if (ctl.lwr_src != SRC_KEEP && !ctl.lwr_fall) begin
          rise_r.lwr <= load_val.lwr ^ fall_r.lwr;
        end
      end
    end

    // Mid-cycle loads; the fed-back value is unsafe to use this cycle.
    always_ff @(negedge pclk or negedge presetn) begin
      if (!presetn) begin
        fall_r <= '{EXT_RESET, WORD_RESET, WORD_RESET};
      end else begin
        if (ctl.ext_src != SRC_KEEP && ctl.ext_fall) begin
          fall_r.guard_extension_field <= load_val.guard_extension_field ^ rise_r.guard_extension_field;
        end
        if (ctl.upr_src != SRC_KEEP && ctl.upr_fall) begin
          fall_r.upr <= load_val.upr ^ rise_r.upr;
        end
        if (ctl.lwr_src != SRC_KEEP && ctl.lwr_fall) begin
          fall_r.lwr <= load_val.lwr ^ rise_r.lwr;
        end
      end
    end

    // Sign flag, updated on the rising edge only.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sign_r <= 1'b0;
      end else begin
        case (ctl.sg)
          SG_ADDER: sign_r <= adder_twos;
          SG_UNS:   sign_r <= 1'b0;
          SG_TWOS:  sign_r <= 1'b1;
          default:  sign_r <= sign_r;
        endcase
      end
    end

    // Registered copy for the port.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc_twos_r[a] <= 1'b0;
      end else begin
        acc_twos_r[a] <= sign_r;
      end
    end
  end

  // ****************************************************************
  // Shift amounts and APB slave
  // ****************************************************************
  logic [SHAMT_W-1:0] shamt_r     [2];
  logic [SHAMT_W-1:0] shamt_nxt   [2];
  logic               apb_access;
  logic               apb_wr;
  logic               hit_shift;
  logic               hit_status;
  logic               hit_lo;
  logic               hit_hi;
  logic               hit_any;
  logic [31:0]        rd_mux;

  // One wait state: the access phase completes on its second edge.
  assign apb_access = psel && penable;
  assign apb_wr     = apb_access && pready_r && pwrite;
  assign hit_shift  = (paddr == OFF_SHIFT);
  assign hit_status = (paddr == OFF_STATUS);
  assign hit_lo     = (paddr == OFF_OUT_LO);
  assign hit_hi     = (paddr == OFF_OUT_HI);
  assign hit_any    = hit_shift || hit_status || hit_lo || hit_hi;
  assign rd_mux     = hit_shift  ? {24'h000000, shamt_r[1], shamt_r[0]} :
                      hit_status ? {30'h00000000, acc_twos_r} :
                      hit_lo     ? shifted_out_r[31:0] :
                      hit_hi     ? {24'h000000, shifted_out_r[39:32]} : 32'h00000000;

  // Y-port writes from the instruction stream take priority over software.
  assign shamt_nxt[0] = status_write ? y_port[3:0] :
                        (shift_write && !shift_write_sel) ? y_port[3:0] :
                        (apb_wr && hit_shift) ? pwdata[3:0] : shamt_r[0];
  assign shamt_nxt[1] = status_write ? y_port[7:4] :
                        (shift_write && shift_write_sel) ? y_port[3:0] :
                        (apb_wr && hit_shift) ? pwdata[7:4] : shamt_r[1];

  // Shift amount storage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shamt_r[0] <= SHAMT_RESET;
      shamt_r[1] <= SHAMT_RESET;
    end else begin
      shamt_r[0] <= shamt_nxt[0];
      shamt_r[1] <= shamt_nxt[1];
    end
  end

  // APB handshake; unmapped addresses answer with an error and zero data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= apb_access && !pready_r;
      pslverr_r <= apb_access && !pready_r && !hit_any;
      prdata_r  <= (apb_access && !pready_r && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ****************************************************************
  // Output shifter
  // ****************************************************************
  logic [ACC_W-1:0]   sh_data;
  logic [SHAMT_W-1:0] sh_amount;
  logic               sh_use;

  // Each accumulator output is steered by its own shift amount; the adder
  // result takes only forced shifts under OSRC_ADDER, but out_src code 3 shifts it by shamt_r[0].
  assign sh_data   = (out_src == OSRC_FIRST)  ? acc_flat[0] :
                     (out_src == OSRC_SECOND) ? acc_flat[1] : adder_result;
  assign sh_amount = (out_src == OSRC_SECOND) ? shamt_r[1] : shamt_r[0];
  assign sh_use    = (out_mode == OMODE_SCR) && (out_src != OSRC_ADDER);

  out_shifter u_shifter (
    .pclk        (pclk),
    .presetn     (presetn),
    .data_in     (sh_data),
    .amount      (sh_amount),
    .use_amount  (sh_use),
    .force_left  (out_mode == OMODE_LEFT1),
    .force_right (out_mode == OMODE_RIGHT1),
    .data_out_r  (shifted_out_r)
  );

endmodule : acc_write_shift

/* rtl/acc_pkg.sv */
/*
  Shared constants and types for the dual accumulator write path and output shifter.
  Assumes a single pclk domain, used on both edges, with an APB register port.
*/
package acc_pkg;

  // ****************************************************************
  // Widths and field positions
  // ****************************************************************
  localparam int ACC_W      = 40;
  localparam int EXT_W      = 8;
  localparam int WORD_W     = 16;
  localparam int SHAMT_W    = 4;
  localparam int FIRST_CODE_MSB  = 15;
  localparam int FIRST_CODE_LSB  = 12;
  localparam int SECOND_CODE_MSB = 11;
  localparam int SECOND_CODE_LSB = 8;
  localparam int MAX_SHIFT  = 7;

  // ****************************************************************
  // Register map and reset values
  // ****************************************************************
  localparam logic [11:0] OFF_SHIFT  = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_OUT_LO = 12'h008;
  localparam logic [11:0] OFF_OUT_HI = 12'h00c;
  localparam logic [3:0]  SHAMT_RESET = 4'h0;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [7:0]  EXT_RESET   = 8'h00;

  // Output source and output shift mode selections.
  localparam logic [1:0] OSRC_ADDER  = 2'h0;
  localparam logic [1:0] OSRC_FIRST  = 2'h1;
  localparam logic [1:0] OSRC_SECOND = 2'h2;
  localparam logic [1:0] OMODE_NONE  = 2'h0;
  localparam logic [1:0] OMODE_SCR   = 2'h1;
  localparam logic [1:0] OMODE_LEFT1 = 2'h2;
  localparam logic [1:0] OMODE_RIGHT1 = 2'h3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {SRC_KEEP, SRC_ADDER, SRC_Y, SRC_ZERO, SRC_SEXT} field_src_type;
  typedef enum logic [1:0] {SG_KEEP, SG_ADDER, SG_UNS, SG_TWOS} sign_mode_type;

  typedef struct packed {
    sign_mode_type sg;
    field_src_type ext_src;
    field_src_type upr_src;
    field_src_type lwr_src;
    logic          ext_fall;
    logic          upr_fall;
    logic          lwr_fall;
  } acc_ctl_type;

  typedef struct packed {
    logic [EXT_W-1:0]  guard_extension_field;
    logic [WORD_W-1:0] upr;
    logic [WORD_W-1:0] lwr;
  } acc_val_type;

  // Decode of one accumulator write code into per-field actions.
  function automatic acc_ctl_type decode_write(input logic [3:0] code);
    acc_ctl_type c;
    c = '{SG_KEEP, SRC_KEEP, SRC_KEEP, SRC_KEEP, 1'b0, 1'b0, 1'b0};
    case (code)
      4'h0: c = '{SG_ADDER, SRC_ADDER, SRC_ADDER, SRC_ADDER, 1'b0, 1'b0, 1'b0};
      4'h1: c = '{SG_UNS, SRC_ZERO, SRC_ZERO, SRC_Y, 1'b0, 1'b0, 1'b0};
      4'h2: c = '{SG_UNS, SRC_ZERO, SRC_Y, SRC_KEEP, 1'b0, 1'b0, 1'b0};
      4'h3: c = '{SG_UNS, SRC_ZERO, SRC_Y, SRC_ZERO, 1'b0, 1'b0, 1'b0};
      4'h4: c = '{SG_KEEP, SRC_Y, SRC_KEEP, SRC_KEEP, 1'b0, 1'b0, 1'b0};
      4'h5: c = '{SG_TWOS, SRC_SEXT, SRC_Y, SRC_ZERO, 1'b0, 1'b0, 1'b0};
      4'h6: c = '{SG_TWOS, SRC_SEXT, SRC_Y, SRC_KEEP, 1'b0, 1'b0, 1'b0};
      4'h7: c = '{SG_KEEP, SRC_KEEP, SRC_KEEP, SRC_KEEP, 1'b0, 1'b0, 1'b0};
      4'h8: c = '{SG_UNS, SRC_ZERO, SRC_ZERO, SRC_ZERO, 1'b0, 1'b0, 1'b0};
      4'h9: c = '{SG_UNS, SRC_ZERO, SRC_ADDER, SRC_ADDER, 1'b0, 1'b0, 1'b0};
      4'ha: c = '{SG_TWOS, SRC_SEXT, SRC_SEXT, SRC_Y, 1'b0, 1'b0, 1'b0};
      4'hb: c = '{SG_KEEP, SRC_Y, SRC_Y, SRC_ZERO, 1'b0, 1'b1, 1'b0};
      4'hc: c = '{SG_UNS, SRC_ZERO, SRC_Y, SRC_Y, 1'b0, 1'b0, 1'b1};
      4'hd: c = '{SG_TWOS, SRC_SEXT, SRC_Y, SRC_Y, 1'b0, 1'b0, 1'b1};
      4'he: c = '{SG_UNS, SRC_ZERO, SRC_Y, SRC_ZERO, 1'b0, 1'b1, 1'b0};
      4'hf: c = '{SG_TWOS, SRC_SEXT, SRC_Y, SRC_ZERO, 1'b1, 1'b1, 1'b0};
      default: c = '{SG_KEEP, SRC_KEEP, SRC_KEEP, SRC_KEEP, 1'b0, 1'b0, 1'b0};
    endcase
    return c;
  endfunction : decode_write

endpackage : acc_pkg

/* rtl/out_shifter.sv */
/*
  Registered 40-bit left/right output shifter, up to seven places.
  Assumes the caller supplies a twos-complement shift amount and force flags.
*/
`timescale 1ns/1ps
module out_shifter
  import acc_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [ACC_W-1:0]    data_in,
  input  wire logic [SHAMT_W-1:0]  amount,
  input  wire logic                use_amount,
  input  wire logic                force_left,
  input  wire logic                force_right,
  output      logic [ACC_W-1:0]    data_out_r
);

  // ****************************************************************
  // Shift count decode
  // ****************************************************************
  logic               amt_neg;
  logic [2:0]         mag;
  logic [ACC_W-1:0]   left_val;
  logic [ACC_W-1:0]   right_val;
  logic [ACC_W-1:0]   data_out_nxt;

  // Negative codes shift left; the most negative is clamped to seven places.
  assign amt_neg   = amount[SHAMT_W-1];
  assign mag       = (amount == 4'h8) ? 3'h7 :
                     amt_neg ? 3'((~amount[2:0]) + 3'h1) : amount[2:0];
  // Left is logical fill, right replicates the sign bit.
  assign left_val  = data_in << mag;
  assign right_val = ACC_W'($signed(data_in) >>> mag);

  // Forced single-place shifts ignore the amount entirely.
  assign data_out_nxt = force_left  ? (data_in << 1) :
                        force_right ? ACC_W'($signed(data_in) >>> 1) :
                        !use_amount ? data_in :
                        amt_neg     ? left_val : right_val;

  // Output register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out_r <= '0;
    end else begin
      data_out_r <= data_out_nxt;
    end
  end

endmodule : out_shifter

/* dv/acc_props.sv */
/* Port checker for the accumulator block.
   Assumes a bind from the bench top and one pclk domain. */
`timescale 1ns/1ps
module acc_props
  import acc_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [15:0]       ucode_word,
  input wire logic [ACC_W-1:0]  adder_result,
  input wire logic              adder_twos,
  input wire logic [1:0]        out_src,
  input wire logic [1:0]        out_mode,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [11:0]       paddr,
  input wire logic              pready_r,
  input wire logic              pslverr_r,
  input wire logic [ACC_W-1:0]  shifted_out_r,
  input wire logic [1:0]        acc_twos_r
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc_req;
  wire logic from_adder;
  // A fresh access edge is one that the slave has not yet answered.
  assign acc_req    = psel && penable && !pready_r;
  assign from_adder = out_src == OSRC_ADDER;
  a_ready_next: assert property (acc_req |=> pready_r)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (pready_r |=> !pready_r)
    else $error("ready held too long");
  a_err_unmapped: assert property (acc_req && paddr > OFF_OUT_HI |=> pslverr_r)
    else $error("unmapped access not refused");
  a_pass_adder: assert property (
    from_adder && out_mode == OMODE_NONE |=> shifted_out_r == $past(adder_result))
    else $error("adder value not passed");
  a_left_one: assert property (
    from_adder && out_mode == OMODE_LEFT1 |=> shifted_out_r == {$past(adder_result[38:0]), 1'b0})
    else $error("forced left shift wrong");
  a_right_one: assert property (
    from_adder && out_mode == OMODE_RIGHT1
    |=> shifted_out_r == {$past(adder_result[39]), $past(adder_result[39:1])})
    else $error("forced right shift not arithmetic");
  a_sign_adder: assert property (
    ucode_word[15:12] == 4'h0 |-> ##2 acc_twos_r[0] == $past(adder_twos, 2))
    else $error("first sign flag does not follow adder");
  a_sign_clear: assert property (ucode_word[11:8] == 4'h8 |-> ##2 !acc_twos_r[1])
    else $error("second sign flag not cleared");
  c_fall_code: cover property (ucode_word[15:12] == 4'hc);
  c_refused: cover property (pslverr_r);
  c_scr_second: cover property (out_mode == OMODE_SCR && out_src == OSRC_SECOND);
endmodule : acc_props

/* dv/ucode_seq.sv */
/* Sequencer model that issues one instruction word per cycle.
   Assumes the caller enters issue just after a rising pclk edge. */
`timescale 1ns/1ps
module ucode_seq (
  input  wire logic        pclk,
  output      logic [15:0] ucode_word,
  output      logic [15:0] y_port
);
  // ****************************************************************
  // Instruction issue
  // ****************************************************************
  // Idle word keeps both accumulators untouched.
  initial begin
    ucode_word = 16'h7700;
    y_port = 16'h0000;
  end
  // Both codes go out in one word; the adder is fed by the bench, never by
  // an accumulator, so a mid-cycle preload cannot loop back the same cycle.
  task automatic issue(input logic [3:0] ca, input logic [3:0] cb,
                       input logic [15:0] yr, input logic [15:0] yf);
    ucode_word <= {ca, cb, 8'h00};
    y_port <= yf;
    @(negedge pclk);
    y_port <= yr;
    @(posedge pclk);
  endtask : issue
endmodule : ucode_seq

/* dv/tb.sv */
/* Self-checking bench for acc_write_shift with a sequencer model.
   Assumes the checker file and ucode_seq are compiled before it. */
`timescale 1ns/1ps
module tb;
  import acc_pkg::*;
  logic pclk, presetn, adder_twos, status_write, shift_write, shift_write_sel;
  logic psel, penable, pwrite, pready_r, pslverr_r, e, tw, sel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_r, q, rs;
  logic [ACC_W-1:0] adder_result, shifted_out_r, ea, eb, ad;
  logic [15:0] ucode_word, y_port, yr, yf;
  logic [1:0] out_src, out_mode, acc_twos_r, es, w, m;
  logic [3:0] sa, sb, ca, cb;
  int failures, n_compared;
  // ****************************************************************
  // Instances, clock and helpers
  // ****************************************************************
  acc_write_shift u_acc_write_shift (.pclk(pclk), .presetn(presetn), .ucode_word(ucode_word),
    .adder_result(adder_result), .adder_twos(adder_twos), .y_port(y_port), .out_src(out_src),
    .out_mode(out_mode), .status_write(status_write), .shift_write(shift_write),
    .shift_write_sel(shift_write_sel), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
    .pslverr_r(pslverr_r), .shifted_out_r(shifted_out_r), .acc_twos_r(acc_twos_r));
  ucode_seq u_ucode_seq (.pclk(pclk), .ucode_word(ucode_word), .y_port(y_port));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  // Next accumulator value; r is Y at the closing rise, f Y at mid-cycle.
  function automatic logic [39:0] nxt_acc(input logic [3:0] c, input logic [39:0] o,
      input logic [39:0] a, input logic [15:0] r, input logic [15:0] f);
    case (c)
      4'h0: return a;
      4'h1: return {24'h0, r};
      4'h2: return {8'h0, r, o[15:0]};
      4'h3: return {8'h0, r, 16'h0};
      4'h4: return {r[7:0], o[31:0]};
      4'h5: return {{8{r[15]}}, r, 16'h0};
      4'h6: return {{8{r[15]}}, r, o[15:0]};
      4'h8: return 40'h0;
      4'h9: return {8'h0, a[31:0]};
      4'ha: return {{24{r[15]}}, r};
      4'hb: return {r[7:0], f, 16'h0};
      4'hc: return {8'h0, r, f};
      4'hd: return {{8{r[15]}}, r, f};
      4'he: return {8'h0, f, 16'h0};
      4'hf: return {{8{f[15]}}, f, 16'h0};
      default: return o;
    endcase
  endfunction : nxt_acc
  function automatic logic nxt_sg(input logic [3:0] c, input logic o, input logic t);
    case (c)
      4'h0: return t;
      4'h4, 4'h7, 4'hb: return o;
      4'h5, 4'h6, 4'ha, 4'hd, 4'hf: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : nxt_sg
  // Negative counts shift left, capped at seven; positive ones shift right.
  function automatic logic [39:0] shf(input logic [39:0] v, input logic [3:0] a,
                                      input logic [1:0] md);
    int n;
    n = 0;
    if (md == OMODE_SCR) n = int'($signed(a));
    if (md == OMODE_LEFT1) n = -1;
    if (md == OMODE_RIGHT1) n = 1;
    if (n < -7) n = -7;
    if (n < 0) return v << -n;
    return $signed(v) >>> n;
  endfunction : shf
  task automatic chk(input string nm, input logic [39:0] x, input logic [39:0] g);
    n_compared++;
    if (g !== x) begin
      $display("Error %s expected %h seen %h", nm, x, g);
      failures++;
    end
  endtask : chk
  task automatic give_verdict();
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // One APB transfer, held until pready is sampled high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready_r !== 1'b1 && k < 20);
    q = prdata_r;
    e = pslverr_r;
    if (k >= 20) begin
      failures++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rs = 32'h59;
    failures = 0;
    n_compared = 0;
    {presetn, adder_twos, status_write, shift_write, shift_write_sel} = '0;
    {psel, penable, pwrite, paddr, pwdata, adder_result, out_src, out_mode} = '0;
    {ea, eb, es, sa, sb} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_SHIFT, 32'h0);
    chk("shift reset", 40'h0, {32'h0, q[7:0]});
    apb(1'b1, OFF_SHIFT, 32'h38);
    apb(1'b1, 12'h010, 32'hff);
    chk("write refused", 40'h1, {39'h0, e});
    apb(1'b0, 12'h010, 32'h0);
    chk("read refused", 40'h1, {7'h0, q, e});
    apb(1'b0, OFF_SHIFT, 32'h0);
    chk("shift readback", 40'h38, {32'h0, q[7:0]});
    sa = 4'h8;
    sb = 4'h3;
    // Each pass issues a code pair, then a keep cycle that shows one accumulator.
    for (int i = 0; i < 80; i++) begin
      ca = (i < 16) ? 4'(i) : 4'(rnd());
      cb = 4'(rnd());
      {yr, yf} = rnd();
      ad = {8'(rnd()), rnd()};
      {tw, sel, w, m} = 6'(rnd());
      adder_result <= ad;
      adder_twos <= tw;
      out_src <= OSRC_ADDER;
      out_mode <= m;
      status_write <= (w == 2'h0);
      shift_write <= (w == 2'h1);
      shift_write_sel <= sel;
      u_ucode_seq.issue(ca, cb, yr, yf);
      if (w == 2'h0) {sb, sa} = yr[7:0];
      if (w == 2'h1 && sel) sb = yr[3:0];
      if (w == 2'h1 && !sel) sa = yr[3:0];
      ea = nxt_acc(ca, ea, ad, yr, yf);
      eb = nxt_acc(cb, eb, ad, yr, yf);
      es = {nxt_sg(cb, es[1], tw), nxt_sg(ca, es[0], tw)};
      status_write <= 1'b0;
      shift_write <= 1'b0;
      m = 2'(rnd());
      out_src <= sel ? OSRC_SECOND : OSRC_FIRST;
      out_mode <= m;
      u_ucode_seq.issue(4'h7, 4'h7, ~yr, yr);
      #1;
      chk("shifted acc", sel ? shf(eb, sb, m) : shf(ea, sa, m), shifted_out_r);
      chk("sign flags", {38'h0, es}, {38'h0, acc_twos_r});
    end
    out_src <= OSRC_FIRST;
    out_mode <= OMODE_SCR;
    @(posedge pclk);
    // The register port shows the shifted value in two pieces, low word first.
    ad = shf(ea, sa, OMODE_SCR);
    apb(1'b0, OFF_OUT_LO, 32'h0);
    chk("out low", {8'h0, ad[31:0]}, {8'h0, q});
    apb(1'b0, OFF_OUT_HI, 32'h0);
    chk("out high", {32'h0, ad[39:32]}, {32'h0, q[7:0]});
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", {38'h0, es}, {38'h0, q[1:0]});
    give_verdict();
  end
endmodule : tb

bind acc_write_shift acc_props u_acc_props (.pclk(pclk), .presetn(presetn),
  .ucode_word(ucode_word), .adder_result(adder_result), .adder_twos(adder_twos),
  .out_src(out_src), .out_mode(out_mode), .psel(psel), .penable(penable), .paddr(paddr),
  .pready_r(pready_r), .pslverr_r(pslverr_r), .shifted_out_r(shifted_out_r),
  .acc_twos_r(acc_twos_r));
